// ---- tlip_defines.vh ----
// constants for the two-level interrupt priority block
`ifndef TLIP_DEFINES_VH
`define TLIP_DEFINES_VH
// ----------------------------------------
// widths and timing
// ----------------------------------------
`define TLIP_NSRC        16
`define TLIP_IDXW        4
`define TLIP_STD_W       8
`define TLIP_CALL_CYC    3'h5
`define TLIP_DETECT_CYC  1
// ----------------------------------------
// sequencer states
// ----------------------------------------
`define TLIP_ST_IDLE     2'h0
`define TLIP_ST_WAIT     2'h1
`define TLIP_ST_CALL     2'h2
`define TLIP_ST_POST     2'h3
`endif

// ---- tlip_prio_reg.v ----
// priority configuration bits, one per source
module tlip_prio_reg #(
  parameter N = 8
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         wr_en,
  input  wire [N-1:0] wr_data,
  output reg  [N-1:0] prio_q
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  // reset to low
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prio_q <= {N{1'b0}};
    end else if (wr_en) begin
      prio_q <= wr_data;
    end
  end
endmodule

// ---- tlip_pick.v ----
// fixed-order pick of the lowest set bit
module tlip_pick #(
  parameter N = 16,
  parameter W = 4
) (
  input  wire [N-1:0] req,
  output reg          any,
  output reg  [W-1:0] idx
);
  integer i;
  // ----------------------------------------
  // lowest index wins
  // ----------------------------------------
  // lower index wins
  always @* begin
    any = 1'b0;
    idx = {W{1'b0}};
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (req[i]) begin
        any = 1'b1;
        idx = i[W-1:0];
      end
    end
  end
endmodule

// ---- tlip_top.v ----
// two-level interrupt priority and dispatch for the core sequencer
`include "tlip_defines.vh"
module tlip_top #(
  parameter NSRC = `TLIP_NSRC,
  parameter IDXW = `TLIP_IDXW,
  parameter STDW = `TLIP_STD_W
) (
  input  wire            REF_CLK,
  input  wire            RESETN,
  input  wire [NSRC-1:0] IRQ_PEND,
  input  wire [NSRC-1:0] IRQ_EN,
  input  wire            GLOBAL_EN,
  input  wire            PRIO_STD_WR,
  input  wire [STDW-1:0] PRIO_STD_DATA,
  input  wire            PRIO_EXT_WR,
  input  wire [NSRC-STDW-1:0] PRIO_EXT_DATA,
  input  wire            INSN_DONE,
  input  wire            INSN_IS_RETURN,
  output reg             VEC_CALL,
  output reg  [IDXW-1:0] VEC_IDX,
  output reg             VEC_HIGH,
  output reg             CALL_BUSY,
  output reg             ACT_LOW,
  output reg             ACT_HIGH,
  output reg  [NSRC-1:0] PRIO_LEVEL
);
  // ----------------------------------------
  // priority registers
  // ----------------------------------------
  wire [STDW-1:0]      prio_std;
  wire [NSRC-STDW-1:0] prio_ext;
  wire [NSRC-1:0]      prio = {prio_ext, prio_std};

  tlip_prio_reg #(.N(STDW)) u_std (
    .clk     (REF_CLK),
    .rst_n   (RESETN),
    .wr_en   (PRIO_STD_WR),
    .wr_data (PRIO_STD_DATA),
    .prio_q  (prio_std)
  );
  tlip_prio_reg #(.N(NSRC-STDW)) u_ext (
    .clk     (REF_CLK),
    .rst_n   (RESETN),
    .wr_en   (PRIO_EXT_WR),
    .wr_data (PRIO_EXT_DATA),
    .prio_q  (prio_ext)
  );

  // ----------------------------------------
  // sampling and decode
  // ----------------------------------------
  reg  [NSRC-1:0] samp_q;
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      samp_q <= {NSRC{1'b0}};
    end else begin
      samp_q <= IRQ_PEND & IRQ_EN & {NSRC{GLOBAL_EN}};
    end
  end

  wire            hi_any;
  wire            lo_any;
  wire [IDXW-1:0] hi_idx;
  wire [IDXW-1:0] lo_idx;
  tlip_pick #(.N(NSRC), .W(IDXW)) u_hi (
    .req (samp_q & prio),
    .any (hi_any),
    .idx (hi_idx)
  );
  tlip_pick #(.N(NSRC), .W(IDXW)) u_lo (
    .req (samp_q & ~prio),
    .any (lo_any),
    .idx (lo_idx)
  );

  // ----------------------------------------
  // eligibility against the active routines
  // ----------------------------------------
  reg  [1:0]      st_q;
  reg  [1:0]      st_d;
  reg  [2:0]      cnt_q;
  reg             act_lo_q;
  reg             act_hi_q;
  reg             elig;
  reg             elig_hi;
  reg  [IDXW-1:0] elig_idx;

  always @* begin
    elig     = 1'b0;
    elig_hi  = 1'b0;
    elig_idx = {IDXW{1'b0}};
    if (!act_hi_q) begin
      if (hi_any) begin
        elig     = 1'b1;
        elig_hi  = 1'b1;
        elig_idx = hi_idx;
      end else if (lo_any && !act_lo_q) begin
        elig     = 1'b1;
        elig_idx = lo_idx;
      end
    end
  end

  // ----------------------------------------
  // dispatch sequencer
  // ----------------------------------------
  // the decision is only made at an instruction boundary, so a request
  // waits for the current instruction; that is where the bench latencies 3 and 9 come from
  always @* begin
    st_d = st_q;
    case (st_q)
      `TLIP_ST_IDLE: begin
        if (elig) begin
          st_d = `TLIP_ST_WAIT;
        end
      end
      `TLIP_ST_WAIT: begin
        if (!elig) begin
          st_d = `TLIP_ST_IDLE;
        // one insn after return
        // a retiring return never fires the call, so the next one does
        end else if (INSN_DONE && !INSN_IS_RETURN) begin
          st_d = `TLIP_ST_CALL;
        end
      end
      `TLIP_ST_CALL: begin
        if (cnt_q == `TLIP_CALL_CYC - 3'h1) begin
          st_d = `TLIP_ST_IDLE;
        end
      end
      default: begin
        st_d = `TLIP_ST_IDLE;
      end
    endcase
  end

  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_q      <= `TLIP_ST_IDLE;
      cnt_q     <= 3'h0;
      act_lo_q  <= 1'b0;
      act_hi_q  <= 1'b0;
      VEC_CALL  <= 1'b0;
      VEC_IDX   <= {IDXW{1'b0}};
      VEC_HIGH  <= 1'b0;
      CALL_BUSY <= 1'b0;
    end else begin
      st_q     <= st_d;
      VEC_CALL <= 1'b0;
      if (INSN_DONE && INSN_IS_RETURN) begin
        if (act_hi_q) begin
          act_hi_q <= 1'b0;
        end else begin
          act_lo_q <= 1'b0;
        end
      end
      if (st_q == `TLIP_ST_WAIT && st_d == `TLIP_ST_CALL) begin
        VEC_CALL  <= 1'b1;
        VEC_IDX   <= elig_idx;
        VEC_HIGH  <= elig_hi;
        CALL_BUSY <= 1'b1;
        cnt_q     <= 3'h0;
        if (elig_hi) begin
          act_hi_q <= 1'b1;
        end else begin
          act_lo_q <= 1'b1;
        end
      end else if (st_q == `TLIP_ST_CALL) begin
        cnt_q <= cnt_q + 3'h1;
        if (st_d == `TLIP_ST_IDLE) begin
          CALL_BUSY <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ACT_LOW    <= 1'b0;
      ACT_HIGH   <= 1'b0;
      PRIO_LEVEL <= {NSRC{1'b0}};
    end else begin
      ACT_LOW    <= act_lo_q;
      ACT_HIGH   <= act_hi_q;
      PRIO_LEVEL <= prio;
    end
  end
endmodule

// ---- tlip_assertions.sv ----
// port assertions for the interrupt priority block
module tlip_chk #(
  parameter NSRC = 16,
  parameter IDXW = 4,
  parameter STDW = 8
) (
  input logic            REF_CLK,
  input logic            RESETN,
  input logic [NSRC-1:0] IRQ_PEND,
  input logic            PRIO_STD_WR,
  input logic [STDW-1:0] PRIO_STD_DATA,
  input logic            INSN_DONE,
  input logic            INSN_IS_RETURN,
  input logic            VEC_CALL,
  input logic [IDXW-1:0] VEC_IDX,
  input logic            VEC_HIGH,
  input logic            CALL_BUSY,
  input logic            ACT_LOW,
  input logic            ACT_HIGH,
  input logic [NSRC-1:0] PRIO_LEVEL
);
  logic [NSRC-1:0] pend_q;
  // requests one edge back: a call answers an earlier sample
  always @(posedge REF_CLK) pend_q <= IRQ_PEND;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  property p_gap; VEC_CALL |=> !VEC_CALL [*6]; endproperty
  a_gap: assert property (p_gap) else $error("calls too close");
  property p_busy; VEC_CALL |-> CALL_BUSY [*5] ##1 !CALL_BUSY; endproperty
  a_busy: assert property (p_busy) else $error("call length");
  property p_hblk; ACT_HIGH |-> !VEC_CALL; endproperty
  a_hblk: assert property (p_hblk) else $error("call in high routine");
  property p_pre; VEC_CALL && ACT_LOW |-> VEC_HIGH; endproperty
  a_pre: assert property (p_pre) else $error("low over low");
  property p_lvl; VEC_CALL && $stable(PRIO_LEVEL) |-> VEC_HIGH == PRIO_LEVEL[VEC_IDX]; endproperty
  a_lvl: assert property (p_lvl) else $error("level flag");
  property p_prio; PRIO_STD_WR |-> ##2 PRIO_LEVEL[STDW-1:0] == $past(PRIO_STD_DATA, 2); endproperty
  a_prio: assert property (p_prio) else $error("priority bits");
  property p_insn; VEC_CALL |-> $past(INSN_DONE && !INSN_IS_RETURN); endproperty
  a_insn: assert property (p_insn) else $error("call without instruction");
  property p_req; VEC_CALL |-> pend_q[VEC_IDX]; endproperty
  a_req: assert property (p_req) else $error("call without request");
  c_high: cover property (VEC_CALL && VEC_HIGH);
  c_low: cover property (VEC_CALL && !VEC_HIGH);
  c_nest: cover property (VEC_CALL && ACT_LOW);
endmodule

// ---- tlip_core_model.sv ----
// core sequencer model that retires instructions
module tlip_core_model (
  input  logic       clk,
  input  logic       rst_n,
  input  logic       busy,
  input  logic [3:0] len,
  input  logic       ret_req,
  output logic       done,
  output logic       is_ret
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  // one instruction per len cycles; stalls while the call runs
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      done <= 1'b0;
      is_ret <= 1'b0;
    end else if (busy) begin
      cnt_q <= 4'h0;
      done <= 1'b0;
    end else if (cnt_q == len - 4'h1) begin
      cnt_q <= 4'h0;
      done <= 1'b1;
      is_ret <= ret_req;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      done <= 1'b0;
    end
  end
endmodule

// ---- tb_top.sv ----
// self-checking bench for the interrupt priority block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rstn = 1'b0, s_wr = 1'b0, e_wr = 1'b0, rq = 1'b0;
  logic [15:0] pend = 16'h0000;
  logic [7:0]  s_d = 8'h00, e_d = 8'h00;
  logic [3:0]  len = 4'h1;
  logic        done, is_ret, vc, vh, busy, alow, ahigh;
  logic [3:0]  vidx;
  logic [15:0] plev;
  int          n_errors = 0, checks = 0, n;
  always #5 clk = ~clk;
  tlip_top tlip_top_i (.REF_CLK(clk), .RESETN(rstn), .IRQ_PEND(pend), .IRQ_EN(16'hffff), .GLOBAL_EN(1'b1),
    .PRIO_STD_WR(s_wr), .PRIO_STD_DATA(s_d), .PRIO_EXT_WR(e_wr), .PRIO_EXT_DATA(e_d), .INSN_DONE(done),
    .INSN_IS_RETURN(is_ret), .VEC_CALL(vc), .VEC_IDX(vidx), .VEC_HIGH(vh), .CALL_BUSY(busy),
    .ACT_LOW(alow), .ACT_HIGH(ahigh), .PRIO_LEVEL(plev));
  tlip_core_model tlip_core_model_i (.clk(clk), .rst_n(rstn), .busy(busy), .len(len), .ret_req(rq),
    .done(done), .is_ret(is_ret));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded wait for a call, then its length; the routine clears its source
  task automatic call(input logic [3:0] idx, input logic hi, input int cyc);
    for (n = 0; vc !== 1'b1 && n < 60; n++) @(negedge clk);
    chk("call_seen", 16'h0001, 16'(vc));
    chk("vec_idx", 16'(idx), 16'(vidx));
    chk("vec_high", 16'(hi), 16'(vh));
    if (cyc > 0) chk("latency", 16'(cyc), 16'(n));
    pend[idx] = 1'b0;
    for (n = 0; busy === 1'b1 && n < 9; n++) @(negedge clk);
    chk("call_cycles", 16'h0005, 16'(n));
  endtask
  task automatic quiet(input int k);
    repeat (k) begin
      @(negedge clk);
      chk("no_call", 16'h0000, 16'(vc));
    end
  endtask
  // core retires one return_from_interrupt
  task automatic ret();
    rq = 1'b1;
    for (n = 0; !(done === 1'b1 && is_ret === 1'b1) && n < 60; n++) @(negedge clk);
    rq = 1'b0;
    chk("ret_seen", 16'h0001, 16'(done & is_ret));
  endtask
  task automatic t_pre();
    s_wr = 1'b1;
    e_wr = 1'b1;
    s_d = 8'h04;
    e_d = 8'h02;
    @(negedge clk);
    s_wr = 1'b0;
    e_wr = 1'b0;
    repeat (2) @(negedge clk);
    chk("prio_level", 16'h0204, plev);
    pend[9] = 1'b1;
    call(4'h9, 1'b1, 3);
    chk("act_high", 16'h0001, 16'(ahigh));
    pend[2] = 1'b1;
    pend[7] = 1'b1;
    quiet(8);
    ret();
    call(4'h2, 1'b1, 0);
    chk("act_low", 16'h0001, 16'(alow));
    ret();
    quiet(8);
    ret();
    call(4'h7, 1'b0, 0);
    ret();
  endtask
  task automatic t_arb();
    repeat (3) @(negedge clk);
    pend = 16'h1206;
    call(4'h2, 1'b1, 3);
    ret();
    call(4'h9, 1'b1, 0);
    ret();
    call(4'h1, 1'b0, 0);
    ret();
    call(4'hc, 1'b0, 0);
    ret();
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk("prio_reset", 16'h0000, plev);
    pend[3] = 1'b1;
    call(4'h3, 1'b0, 3);
    pend[5] = 1'b1;
    quiet(8);
    len = 4'h5;
    ret();
    len = 4'h8;
    call(4'h5, 1'b0, 9);
    len = 4'h1;
    t_pre();
    t_arb();
    end_sim();
  end
  // watchdog: the run needs well under a thousand cycles
  initial begin
    #100us;
    n_errors++;
    end_sim();
  end
endmodule
bind tlip_top tlip_chk #(.NSRC(NSRC), .IDXW(IDXW), .STDW(STDW)) tlip_chk_i (.*);
